// [core/pdm_pin_cell.sv]
// one port pin: direction, driver enable and input sampling
module pdm_pin_cell (
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  input  wire logic dir_in,
  input  wire logic latch_in,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_n_out,
  output logic      level_out
);

  ////////////////////////////////////////////////////////////////////////////
  // driver follows direction; input mode keeps the driver released
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pad_out      <= 1'b0;
      pad_oe_n_out <= 1'b1;
      level_out    <= 1'b0;
    end else begin
      pad_oe_n_out <= ~dir_in;                   // RL3 RL4
      pad_out      <= dir_in & latch_in;         // RL4
      level_out    <= dir_in ? latch_in : pad_in; // input mode reads the pad
    end
  end

endmodule : pdm_pin_cell

// [core/pdm_top.sv]
// direction mode registers for ports 4.0, 6, 7, 8 and 9 behind an Avalon-MM slave
//
// Register access over Avalon-MM was left to the implementer.
module pdm_top #(
  parameter int PORT_PINS = pdm_pkg::PORT_PINS,
  parameter int PIN_CNT   = pdm_pkg::PIN_CNT
) (
  input  wire logic                        mclk_in,
  input  wire logic                        resetn_in,
  input  wire logic [pdm_pkg::ADDR_W-1:0]  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [pdm_pkg::DATA_W-1:0]  avs_writedata_in,
  input  wire logic [pdm_pkg::BE_W-1:0]    avs_byteenable_in,
  output logic      [pdm_pkg::DATA_W-1:0]  avs_readdata_out,
  output logic                             avs_waitrequest_out,
  output logic      [1:0]                  avs_response_out,
  input  wire logic [PIN_CNT-1:0]          port_latch_in,
  input  wire logic [PIN_CNT-1:0]          pad_in,
  output logic      [PIN_CNT-1:0]          pad_out,
  output logic      [PIN_CNT-1:0]          pad_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks: two ports share one byte register
  if (2 * PORT_PINS != pdm_pkg::REG_W) begin : g_chk_pins
    $error("pdm_top: two ports of PORT_PINS must fill one register");
  end
  if (PIN_CNT != 4 * PORT_PINS + 1) begin : g_chk_cnt
    $error("pdm_top: PIN_CNT must be four ports plus port 4 pin 0");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode helper, shared by every register
  function automatic logic pdm_hit(input logic [pdm_pkg::ADDR_W-1:0] addr,
                                   input logic [11:0]                idx);
    pdm_hit = (addr == {idx, 2'b00});
  endfunction : pdm_hit

  ////////////////////////////////////////////////////////////////////////////
  // local widths and slots
  localparam int DW     = pdm_pkg::DATA_W;
  localparam int RW     = pdm_pkg::REG_W;
  localparam int P4_IDX = PIN_CNT - 1;       // port 4 pin 0 sits above both groups

  // the level word must fit in one bus word
  if (PIN_CNT > DW) begin : g_chk_bus
    $error("pdm_top: PIN_CNT exceeds the bus data width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake state
  pdm_pkg::pdm_state_t              state_r;
  pdm_pkg::pdm_state_t              state_nxt;
  logic                             wait_r;
  logic                             wait_nxt;
  logic [DW-1:0]                    rdata_r;
  logic [DW-1:0]                    rdata_nxt;
  logic [1:0]                       resp_r;
  logic [1:0]                       resp_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // direction registers
  logic [RW-1:0]                    grp4_r;
  logic [RW-1:0]                    grp4_nxt;
  logic [RW-1:0]                    grp5_r;
  logic [RW-1:0]                    grp5_nxt;
  logic                             p4_dir_r;
  logic                             p4_dir_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode wires
  logic                             req_w;
  logic                             hit_grp3_w;
  logic                             hit_grp4_w;
  logic                             hit_grp5_w;
  logic                             hit_level_w;
  logic                             hit_any_w;
  logic                             commit_w;
  logic [RW-1:0]                    wr_byte_w;
  logic [DW-1:0]                    rd_value_w;
  logic [PIN_CNT-1:0]               dir_w;

  ////////////////////////////////////////////////////////////////////////////
  // pin side nets; each bit has its own pin cell as driver
  wire logic [PIN_CNT-1:0]          pad_w;
  wire logic [PIN_CNT-1:0]          oen_w;
  wire logic [PIN_CNT-1:0]          level_w;

  ////////////////////////////////////////////////////////////////////////////
  // address decode; one function keeps all compares alike
  assign req_w       = avs_read_in | avs_write_in;
  assign hit_grp3_w  = pdm_hit(avs_address_in, pdm_pkg::IDX_GRP3);   // RL5
  assign hit_grp4_w  = pdm_hit(avs_address_in, pdm_pkg::IDX_GRP4);   // RL1
  assign hit_grp5_w  = pdm_hit(avs_address_in, pdm_pkg::IDX_GRP5);   // RL2
  assign hit_level_w = pdm_hit(avs_address_in, pdm_pkg::IDX_LEVEL);
  assign hit_any_w   = hit_grp3_w | hit_grp4_w | hit_grp5_w | hit_level_w;

  // write lands only at the edge where the master sees waitrequest low;
  // lane 0 must be enabled, as the registers take whole bytes only
  assign commit_w  = (state_r == pdm_pkg::PDM_ACK) & avs_write_in & avs_byteenable_in[0]; // RL6
  assign wr_byte_w = avs_writedata_in[RW-1:0];

  // read data: direction registers are write-only and read back as zero
  assign rd_value_w = hit_level_w ? DW'(level_w) : '0; // RL6

  ////////////////////////////////////////////////////////////////////////////
  // next values of the direction registers
  assign grp4_nxt   = (commit_w && hit_grp4_w) ? wr_byte_w : grp4_r;                  // RL1
  assign grp5_nxt   = (commit_w && hit_grp5_w) ? wr_byte_w : grp5_r;                  // RL2
  assign p4_dir_nxt = (commit_w && hit_grp3_w) ? wr_byte_w[pdm_pkg::P4_BIT] : p4_dir_r; // RL5

  // per-pin direction: group 4 low, group 5 above, port 4 pin 0 on top
  assign dir_w = {p4_dir_r, grp5_r, grp4_r}; // RL1 RL2 RL5

  ////////////////////////////////////////////////////////////////////////////
  // handshake: one wait cycle, then a single cycle with waitrequest low;
  // the answer is registered so every bus output leaves a flip-flop
  always_comb begin
    state_nxt = state_r;
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    resp_nxt  = resp_r;
    case (state_r)
      pdm_pkg::PDM_IDLE: begin
        if (req_w) begin
          state_nxt = pdm_pkg::PDM_ACK;
          wait_nxt  = 1'b0;
          resp_nxt  = hit_any_w ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_ERR;
          rdata_nxt = avs_read_in ? rd_value_w : '0;
        end
      end
      pdm_pkg::PDM_ACK: begin
        // back to idle so a held request is never taken twice
        state_nxt = pdm_pkg::PDM_IDLE;
      end
      default: begin
        state_nxt = pdm_pkg::PDM_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus registers; waitrequest stays high through reset
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_r <= pdm_pkg::PDM_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= '0;
      resp_r  <= pdm_pkg::RESP_OKAY;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      resp_r  <= resp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction registers; reset makes every covered pin an input
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      grp4_r   <= pdm_pkg::DIR_RST;                 // RL6
      grp5_r   <= pdm_pkg::DIR_RST;                 // RL6
      p4_dir_r <= pdm_pkg::DIR_RST[pdm_pkg::P4_BIT]; // RL6
    end else begin
      grp4_r   <= grp4_nxt;
      grp5_r   <= grp5_nxt;
      p4_dir_r <= p4_dir_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one cell per pin; the cell registers driver and enable,
  // so a new direction reaches the pad one cycle after the write
  for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
    pdm_pin_cell u_cell (
      .mclk_in      (mclk_in),
      .resetn_in    (resetn_in),
      .dir_in       (dir_w[i]),
      .latch_in     (port_latch_in[i]),
      .pad_in       (pad_in[i]),
      .pad_out      (pad_w[i]),
      .pad_oe_n_out (oen_w[i]),
      .level_out    (level_w[i])
    );
  end : g_pin

  ////////////////////////////////////////////////////////////////////////////
  // outputs; all of them leave flip-flops
  assign avs_readdata_out    = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign avs_response_out    = resp_r;
  assign pad_out             = pad_w;
  assign pad_oe_n_out        = oen_w;   // RL3 RL4

endmodule : pdm_top

// [pkg/pdm_pkg.sv]
// constants for the port direction mode register block
//
// Contract
// RL1 - the group-4 register at index FECH drives port 6 pins 0-3 from bits 0-3 and port 7 pins 0-3 from bits 4-7.
// RL2 - the group-5 register at index FEEH drives port 8 pins 0-3 from bits 0-3 and port 9 pins 0-3 from bits 4-7.
// RL3 - a direction bit at zero puts its pin in input mode with the output driver off.
// RL4 - a direction bit at one puts its pin in output mode, driven from its output latch.
// RL5 - bit 0 of the group-3 register makes port 4 pin 0 an input when zero and an output when one.
// RL6 - both direction registers clear to zero on reset and are written as whole write-only bytes.
package pdm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_GRP3  = 12'hFEA;
  localparam logic [11:0] IDX_GRP4  = 12'hFEC;
  localparam logic [11:0] IDX_GRP5  = 12'hFEE;
  localparam logic [11:0] IDX_LEVEL = 12'hFF0;
  localparam int          ADDR_W    = 14;
  localparam int          DATA_W    = 32;
  localparam int          BE_W      = 4;

  ////////////////////////////////////////////////////////////////////////////
  // field layout and reset values
  localparam int          REG_W     = 8;
  localparam int          PORT_PINS = 4;
  localparam int          PIN_CNT   = 17;
  localparam int          P4_BIT    = 0;
  localparam int          P4_SLOT   = 16;
  localparam logic [7:0]  DIR_RST   = 8'h00;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  // bus handshake states
  typedef enum logic [0:0] {
    PDM_IDLE,
    PDM_ACK
  } pdm_state_t;

endpackage : pdm_pkg

// [verification/pdm_top_monitor.sv]
// port checks for the direction block
module pdm_mon #(parameter int PIN_CNT = pdm_pkg::PIN_CNT) (
  input wire logic               mclk_in,
  input wire logic               resetn_in,
  input wire logic               avs_write_in,
  input wire logic               avs_waitrequest_out,
  input wire logic [pdm_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic [PIN_CNT-1:0] port_latch_in,
  input wire logic [PIN_CNT-1:0] pad_out,
  input wire logic [PIN_CNT-1:0] pad_oe_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  rst_in_a: assert property ($rose(resetn_in) |-> &pad_oe_n_out) else $error("not input");
  drv_a: assert property (pad_out == (~pad_oe_n_out & $past(port_latch_in))) else $error("drive");
  wr_a: assert property ($changed(pad_oe_n_out) |-> $past(avs_write_in && !avs_waitrequest_out, 2)) else $error("wr");
  g4_a: assert property ($changed(pad_oe_n_out[7:0]) |-> $past(avs_address_in[13:2] == pdm_pkg::IDX_GRP4, 2)) else $error("g4");
  g5_a: assert property ($changed(pad_oe_n_out[15:8]) |-> $past(avs_address_in[13:2] == pdm_pkg::IDX_GRP5, 2)) else $error("g5");
  g3_a: assert property ($changed(pad_oe_n_out[16]) |-> $past(avs_address_in[13:2] == pdm_pkg::IDX_GRP3, 2)) else $error("g3");
  ack_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("ack");
endmodule : pdm_mon
bind pdm_top pdm_mon #(.PIN_CNT(PIN_CNT)) mon (.*);

// [verification/tb.sv]
// bench for the direction block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, resetn_in = 0, wr = 0, rd = 0, wt;
  logic [31:0] rdat;
  logic [1:0] rsp;
  logic [33:0] bus_q[$];
  logic [13:0] adr = 0;
  logic [31:0] wd = 0;
  logic [16:0] lat = 0, pin, oen, exp_q[$];
  int error_cnt = 0, checks_done = 0, seed = 32'h4e7787b5;
  event got;
  always #2.5 mclk_in = ~mclk_in;
  pdm_top uut (.mclk_in, .resetn_in, .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .avs_response_out(rsp), .port_latch_in(lat), .pad_in(lat), .pad_out(pin), .pad_oe_n_out(oen));
  // one bus transfer; the expected answer is noted before the request goes out
  task automatic xfer(input logic w, input logic [11:0] i, input logic [7:0] d, input logic [33:0] e);
    bus_q.push_back(e);
    @(posedge mclk_in) {wr, rd, adr, wd} <= {w, !w, i, 2'h0, 24'h0, d};
    do @(posedge mclk_in); while (wt !== 1'b0);
    {wr, rd} <= 2'b00;
  endtask : xfer
  // compare each bus answer at the edge that ends its transfer
  always @(posedge mclk_in) if ((wr || rd) && wt === 1'b0) begin
    checks_done++;
    if ({rsp, rdat} !== bus_q[0]) begin error_cnt++; $display("FAIL %0t bus", $time); end
    void'(bus_q.pop_front());
  end
  task test_done;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // compare pins against the oldest note
  always @got begin
    checks_done++;
    if (oen !== exp_q[0] || (pin | oen) !== (lat | oen)) begin error_cnt++; $display("FAIL %0t pins", $time); end
    void'(exp_q.pop_front());
  end
  initial begin #20000; error_cnt++; test_done(); end
  initial begin
    logic [7:0] g [3];
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1;
    exp_q.push_back('1);
    @(posedge mclk_in) #1 ->got;
    repeat (6) begin
      foreach (g[i]) g[i] = 8'($random(seed));
      @(posedge mclk_in) lat <= 17'($random(seed));
      xfer(1'b1, 12'hFEC, g[0], {pdm_pkg::RESP_OKAY, 32'h0});
      xfer(1'b1, 12'hFEE, g[1], {pdm_pkg::RESP_OKAY, 32'h0});
      xfer(1'b1, 12'hFEA, g[2], {pdm_pkg::RESP_OKAY, 32'h0});
      xfer(1'b1, 12'h123, 8'hFF, {pdm_pkg::RESP_ERR, 32'h0});
      xfer(1'b0, 12'hFF0, 8'h00, {pdm_pkg::RESP_OKAY, 15'h0, lat});
      xfer(1'b0, 12'hFEC, 8'h00, {pdm_pkg::RESP_OKAY, 32'h0});
      exp_q.push_back(~{g[2][0], g[1], g[0]});
      @(posedge mclk_in) #1 ->got;
    end
    test_done();
  end
endmodule : tb
